// ### hdl/adc_link_pkg.sv
package adc_link_pkg;
  // ==========================================================
  // Command byte layout
  localparam int CMD_WEN_BIT = 7;
  localparam int CMD_DIR_BIT = 6;
  localparam int CMD_SEL_HI = 5;
  localparam int CMD_SEL_LO = 3;
  localparam int CMD_CONTINUOUS_RESULT_READ_BIT = 2;
  localparam logic [7:0] CMD_LOW_MASK = 8'h03;
  localparam logic [7:0] CMD_CONTINUOUS_RESULT_READ_ENTER = 8'h5C;
  localparam logic [7:0] CMD_CONTINUOUS_RESULT_READ_EXIT = 8'h58;
  // ==========================================================
  // Register select codes
  localparam logic [2:0] SEL_COMM_STATUS = 3'h0;
  localparam logic [2:0] SEL_MODE = 3'h1;
  localparam logic [2:0] SEL_SETUP = 3'h2;
  localparam logic [2:0] SEL_RESULT = 3'h3;
  localparam logic [2:0] SEL_IDENT = 3'h4;
  localparam logic [2:0] SEL_PINS = 3'h5;
  localparam logic [2:0] SEL_ZERO = 3'h6;
  localparam logic [2:0] SEL_GAIN = 3'h7;
  // ==========================================================
  // Sizes, reset values, field positions
  localparam logic [5:0] LEN_BYTE = 6'h08;
  localparam logic [5:0] LEN_WORD = 6'h18;
  localparam logic [5:0] LEN_LONG = 6'h20;
  localparam logic [5:0] RESET_ONES = 6'h28;
  localparam logic [7:0] STATUS_RESET = 8'h80;
  localparam int ST_RDY = 7;
  localparam int ST_ERR = 6;
  localparam int ST_REFERENCE_MISSING_FLAG = 5;
  localparam int ST_PARITY = 4;
  localparam logic [23:0] MODE_RESET = 24'h08_0060;
  localparam logic [23:0] SETUP_RESET = 24'h00_0117;
  localparam logic [23:0] ZERO_RESET = 24'h80_0000;
  localparam logic [7:0] PINS_RESET = 8'h00;
  localparam int MODE_STATUS_APPEND_BIT = 20;
  localparam int MODE_PARITY_EN_BIT = 13;
  // ==========================================================
  // Controller registers (APB byte addresses) and fields
  localparam logic [7:0] ADDR_TX_CMD = 8'h00;
  localparam logic [7:0] ADDR_TX_DATA = 8'h04;
  localparam logic [7:0] ADDR_RX_DATA = 8'h08;
  localparam logic [7:0] ADDR_LINK_STATE = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
  localparam int CMDF_LEN_LO = 8;
  localparam int CMDF_LEN_HI = 13;
  localparam int CMDF_DATA_ONLY = 16;
  localparam int CMDF_RESET = 17;
  localparam int CMDF_WAIT_RDY = 18;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_READY = 1;
  // ==========================================================
  // Serial clock timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int SCLK_PERIOD_NS = 64;
  localparam logic [3:0] SCLK_HALF =
    4'(SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS));

  // Bits that follow the command byte for a given access
  function automatic logic [5:0] reg_len(input logic [2:0] sel,
                                         input logic is_read,
                                         input logic append);
    logic [5:0] n;
    n = LEN_WORD;
    case (sel)
      SEL_COMM_STATUS: n = is_read ? LEN_BYTE : 6'h00;
      SEL_RESULT: n = append ? LEN_LONG : LEN_WORD;
      SEL_IDENT, SEL_PINS: n = LEN_BYTE;
      default: n = LEN_WORD;
    endcase
    return n;
  endfunction
endpackage

// ### hdl/adc_link_if.sv
`timescale 1ns/10ps
interface adc_link_if;
  logic sclk;
  logic din;
  logic dout;
  logic data_ready_n;
  modport device (input sclk, input din, output dout, output data_ready_n);
  modport host (output sclk, output din, input dout, input data_ready_n);
endinterface

// ### hdl/adc_serial_device.sv
// What this block does
// R1: Direction bit one reads, zero writes
// R2: Select bits pick mode, setup, ident, pins, calibration
// R3: Code 000 is command on write, status on read
// R4: Code 011 reads 24 result bits or 32
// R5: Continuous mode shifts each new result out
// R6: No command byte between continuous result reads
// R7: Master enters continuous mode with 01011100
// R8: Master leaves with 01011000 while ready low
// R9: Serial input watched during continuous mode
// R10: Forty ones reset; master holds input low
// R11: Master writes zeros in two low bits
// R12: Status is 8 bits, read-only, resets 0x80
// R13: Status read is command then eight bits
// R14: Status: ready, error, reference_missing_flag, parity, channel
// R15: Command waits for leading zero gate bit
// R16: Back to command wait after each access
// R17: Forty ones resynchronise to command wait
//
// Local design decision: the APB register port.
`timescale 1ns/10ps
module adc_serial_device #(
  parameter logic [7:0] IDENT_VALUE = 8'h5A,
  parameter logic [23:0] GAIN_RESET = 24'h50_0000
) (
  input wire logic pclk,
  input wire logic presetn,
  adc_link_if.device link,
  input wire logic conv_done,
  input wire logic [23:0] conv_data,
  input wire logic conv_error,
  input wire logic conv_reference_missing_flag,
  input wire logic [3:0] conv_channel,
  output logic [23:0] operating_mode,
  output logic [23:0] channel_setup,
  output logic [7:0] output_pin_control,
  output logic [23:0] zero_calibration,
  output logic [23:0] gain_calibration,
  output logic serial_reset
);
  import adc_link_pkg::*;

  typedef enum logic [1:0] {S_CMD, S_XFER, S_CONTINUOUS_RESULT_READ} dev_state_t;

  typedef struct packed {
    logic [1:0] sclk_sync;
    logic [1:0] din_sync;
    logic sclk_prev;
    dev_state_t st;
    logic [5:0] cnt;
    logic [5:0] len;
    logic is_read;
    logic [2:0] sel;
    logic [31:0] sh;
    logic [7:0] cmd_sh;
    logic [5:0] ones;
    logic [7:0] status;
    logic [23:0] result;
    logic [23:0] mode;
    logic [23:0] setup;
    logic [23:0] zero;
    logic [23:0] gain;
    logic [7:0] pins;
    logic dout;
    logic ready_n;
    logic sreset;
  } dev_t;

  localparam dev_t RST = '{
    sclk_sync: 2'h3, din_sync: 2'h3, sclk_prev: 1'b1, st: S_CMD,
    cnt: 6'h00, len: 6'h00, is_read: 1'b0, sel: 3'h0, sh: 32'h0000_0000,
    cmd_sh: 8'h00, ones: 6'h00, status: STATUS_RESET,
    result: 24'h00_0000, mode: MODE_RESET, setup: SETUP_RESET,
    zero: ZERO_RESET, gain: GAIN_RESET, pins: PINS_RESET,
    dout: 1'b1, ready_n: STATUS_RESET[ST_RDY], sreset: 1'b0};

  dev_t q, d;

  // Left-aligned word that a read of a register shifts out
  function automatic logic [31:0] load_word(input dev_t s,
                                            input logic [2:0] sel);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (sel)
      SEL_COMM_STATUS: w = {s.status, 24'h00_0000};
      SEL_MODE: w = {s.mode, 8'h00};
      SEL_SETUP: w = {s.setup, 8'h00};
      SEL_RESULT: w = {s.result,
                       s.mode[MODE_STATUS_APPEND_BIT] ? s.status : 8'h00};
      SEL_IDENT: w = {IDENT_VALUE, 24'h00_0000};
      SEL_PINS: w = {s.pins, 24'h00_0000};
      SEL_ZERO: w = {s.zero, 8'h00};
      SEL_GAIN: w = {s.gain, 8'h00};
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  logic rise;
  logic sin;
  logic [7:0] byte_in;
  logic [31:0] sh_in;
  logic [5:0] cnt_nx;

  always_comb begin
    d = q;
    d.sreset = 1'b0;
    d.sclk_sync = {q.sclk_sync[0], link.sclk};
    d.din_sync = {q.din_sync[0], link.din};
    d.sclk_prev = q.sclk_sync[1];
    rise = q.sclk_sync[1] & ~q.sclk_prev;
    sin = q.din_sync[1];
    byte_in = {q.cmd_sh[6:0], sin};
    sh_in = {q.sh[30:0], sin};
    cnt_nx = q.cnt + 6'h01;

    // ==========================================================
    // Conversion results; a new result is only loaded into the
    // shifter at the start of a read, so a running read is safe
    if (conv_done) begin
      d.result = conv_data;
      d.status = {1'b0, conv_error, conv_reference_missing_flag,
                  q.mode[MODE_PARITY_EN_BIT] & (^conv_data),
                  conv_channel}; // see R14
    end

    // ==========================================================
    // Serial engine, stepped on each rising serial clock edge
    if (q.st == S_CONTINUOUS_RESULT_READ && q.cnt == 6'h00 && !rise) begin
      d.sh = load_word(q, SEL_RESULT); // see R5
      d.dout = d.sh[31];
    end
    if (rise) begin
      d.ones = sin ? cnt_ones(q.ones) : 6'h00;
      case (q.st)
        S_CMD: begin
          if (q.cnt == 6'h00 && sin) begin
            d.cnt = 6'h00; // see R15
          end else begin
            d.cmd_sh = byte_in;
            d.cnt = cnt_nx;
            if (q.cnt == LEN_BYTE - 6'h01) begin
              d.cnt = 6'h00;
              d.is_read = byte_in[CMD_DIR_BIT]; // see R1
              d.sel = byte_in[CMD_SEL_HI:CMD_SEL_LO]; // see R2
              d.len = reg_len(d.sel, d.is_read,
                              q.mode[MODE_STATUS_APPEND_BIT]); // see R4
              d.sh = load_word(q, d.sel);
              if (d.is_read && d.sel == SEL_RESULT &&
                  byte_in[CMD_CONTINUOUS_RESULT_READ_BIT]) begin
                d.st = S_CONTINUOUS_RESULT_READ; // see R6
              end else if (d.len != 6'h00) begin
                d.st = S_XFER; // see R3
                if (d.is_read) begin
                  d.dout = d.sh[31];
                end
              end
            end
          end
        end
        S_XFER: begin
          d.sh = sh_in;
          d.dout = q.sh[30];
          d.cnt = cnt_nx;
          if (cnt_nx == q.len) begin
            d.st = S_CMD; // see R16
            d.cnt = 6'h00;
            if (q.is_read) begin
              if (q.sel == SEL_RESULT) begin
                d.status[ST_RDY] = 1'b1;
              end
            end else begin
              case (q.sel)
                SEL_MODE: begin
                  d.mode = sh_in[23:0];
                  d.status[ST_RDY] = 1'b1;
                end
                SEL_SETUP: d.setup = sh_in[23:0];
                SEL_PINS: d.pins = sh_in[7:0];
                SEL_ZERO: d.zero = sh_in[23:0];
                SEL_GAIN: d.gain = sh_in[23:0];
                default: d.pins = q.pins; // Read-only targets: see R12
              endcase
            end
          end
        end
        S_CONTINUOUS_RESULT_READ: begin
          d.cmd_sh = byte_in; // see R9
          d.sh = sh_in;
          d.dout = q.sh[30];
          d.cnt = cnt_nx;
          if (cnt_nx == reg_len(SEL_RESULT, 1'b1,
                                q.mode[MODE_STATUS_APPEND_BIT])) begin
            d.cnt = 6'h00;
            d.status[ST_RDY] = 1'b1;
          end
          // Exit byte is recognised at any bit position of input, not only on byte boundaries
          if (byte_in == CMD_CONTINUOUS_RESULT_READ_EXIT) begin
            d.st = S_CMD;
            d.cnt = 6'h00;
          end
        end
        default: d.st = S_CMD;
      endcase
      if (sin && cnt_ones(q.ones) == RESET_ONES) begin
        d = RST; // see R10
        d.sclk_sync = {q.sclk_sync[0], link.sclk};
        d.din_sync = {q.din_sync[0], link.din};
        d.sclk_prev = q.sclk_sync[1];
        d.sreset = 1'b1; // see R17
      end
    end
    if (conv_done && !d.sreset) begin
      d.status[ST_RDY] = 1'b0; // New data wins over a completing read
    end
    d.ready_n = d.status[ST_RDY];
  end

  // Saturating count of consecutive ones
  function automatic logic [5:0] cnt_ones(input logic [5:0] n);
    return (n == RESET_ONES) ? n : n + 6'h01;
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= RST;
    end else begin
      q <= d;
    end
  end

  assign link.dout = q.dout;
  assign link.data_ready_n = q.ready_n;
  assign operating_mode = q.mode;
  assign channel_setup = q.setup;
  assign output_pin_control = q.pins;
  assign zero_calibration = q.zero;
  assign gain_calibration = q.gain;
  assign serial_reset = q.sreset;
endmodule // adc_serial_device

// ### hdl/adc_serial_host.sv
`timescale 1ns/10ps
module adc_serial_host (
  input wire logic pclk,
  input wire logic presetn,
  adc_link_if.host link,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq
);
  import adc_link_pkg::*;

  typedef enum logic [1:0] {H_IDLE, H_WAIT, H_LOW, H_HIGH} host_state_t;

  typedef struct packed {
    logic [1:0] dout_sync;
    logic [1:0] rdy_sync;
    logic rdy_prev;
    host_state_t st;
    logic [3:0] div;
    logic [5:0] bits;
    logic [39:0] tx;
    logic [31:0] rx;
    logic [31:0] tx_data;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic sclk;
    logic din;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic irq;
  } host_t;

  localparam host_t RST = '{
    dout_sync: 2'h3, rdy_sync: 2'h3, rdy_prev: 1'b1, st: H_IDLE,
    div: 4'h0, bits: 6'h00, tx: 40'h00_0000_0000, rx: 32'h0000_0000,
    tx_data: 32'h0000_0000, irq_stat: 2'h0, irq_mask: 2'h0,
    sclk: 1'b1, din: 1'b1, pready: 1'b0, pslverr: 1'b0,
    prdata: 32'h0000_0000, irq: 1'b0};

  host_t q, d;
  logic setup_ph;
  logic done;
  logic [5:0] len;
  logic [7:0] cmd;

  always_comb begin
    d = q;
    d.dout_sync = {q.dout_sync[0], link.dout};
    d.rdy_sync = {q.rdy_sync[0], link.data_ready_n};
    d.rdy_prev = q.rdy_sync[1];
    setup_ph = psel & ~penable;
    done = psel & penable & q.pready;
    len = pwdata[CMDF_LEN_HI:CMDF_LEN_LO];
    cmd = pwdata[7:0] & ~CMD_LOW_MASK; // Low two bits forced: see R11

    // ==========================================================
    // APB slave: no wait states, answer registered in setup
    d.pready = setup_ph;
    d.pslverr = 1'b0;
    if (setup_ph) begin
      case (paddr)
        ADDR_TX_CMD: d.prdata = {31'h0000_0000, q.st != H_IDLE};
        ADDR_TX_DATA: d.prdata = q.tx_data;
        ADDR_RX_DATA: d.prdata = q.rx;
        ADDR_LINK_STATE: d.prdata = {30'h0000_0000, q.rdy_sync[1],
                                     q.st != H_IDLE};
        ADDR_IRQ_STATUS: d.prdata = {30'h0000_0000, q.irq_stat};
        ADDR_IRQ_MASK: d.prdata = {30'h0000_0000, q.irq_mask};
        default: begin
          d.prdata = 32'h0000_0000;
          d.pslverr = 1'b1;
        end
      endcase
    end
    if (done && !pwrite && paddr == ADDR_IRQ_STATUS) begin
      d.irq_stat = 2'h0;
    end
    if (done && pwrite) begin
      case (paddr)
        ADDR_TX_DATA: d.tx_data = pwdata;
        ADDR_IRQ_MASK: d.irq_mask = pwdata[1:0];
        ADDR_TX_CMD: begin
          if (q.st == H_IDLE) begin
            if (pwdata[CMDF_RESET]) begin
              d.tx = {40{1'b1}}; // see R17
              d.bits = RESET_ONES;
            end else if (pwdata[CMDF_DATA_ONLY]) begin
              d.tx = 40'h00_0000_0000; // Input held low: see R10
              d.bits = len; // see R6
            end else begin
              d.tx = {cmd, q.tx_data << (LEN_LONG - len)}; // see R7
              d.bits = LEN_BYTE + len; // see R13
            end
            d.st = pwdata[CMDF_WAIT_RDY] ? H_WAIT : H_LOW; // see R8
            d.div = 4'h0;
            d.rx = 32'h0000_0000;
          end
        end
        default: d.tx_data = q.tx_data;
      endcase
    end

    // ==========================================================
    // Serial engine: drive on the falling edge, sample at the end
    // of the low phase so the device has settled its output
    case (q.st)
      H_IDLE: begin
        d.sclk = 1'b1;
        if (d.st == H_LOW) begin
          d.sclk = 1'b0;
          d.din = d.tx[39];
        end
      end
      H_WAIT: begin
        if (!q.rdy_sync[1]) begin
          d.st = H_LOW;
          d.sclk = 1'b0;
          d.din = q.tx[39];
        end
      end
      H_LOW: begin
        d.div = q.div + 4'h1;
        if (q.div == SCLK_HALF - 4'h1) begin
          d.div = 4'h0;
          d.sclk = 1'b1;
          d.rx = {q.rx[30:0], q.dout_sync[1]};
          d.st = H_HIGH;
        end
      end
      H_HIGH: begin
        d.div = q.div + 4'h1;
        if (q.div == SCLK_HALF - 4'h1) begin
          d.div = 4'h0;
          d.bits = q.bits - 6'h01;
          d.tx = {q.tx[38:0], 1'b0};
          if (q.bits == 6'h01) begin
            d.st = H_IDLE;
            d.din = 1'b1;
            d.irq_stat[IRQ_DONE] = 1'b1;
          end else begin
            d.st = H_LOW;
            d.sclk = 1'b0;
            d.din = q.tx[38];
          end
        end
      end
      default: d.st = H_IDLE;
    endcase
    if (q.rdy_prev && !q.rdy_sync[1]) begin
      d.irq_stat[IRQ_READY] = 1'b1;
    end
    d.irq = |(d.irq_stat & d.irq_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= RST;
    end else begin
      q <= d;
    end
  end

  assign link.sclk = q.sclk;
  assign link.din = q.din;
  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign irq = q.irq;
endmodule // adc_serial_host

// ### verification/adc_serial_register_access_assertions.sv
`timescale 1ns/10ps
module adc_link_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sclk,
  input wire logic din,
  input wire logic dout,
  input wire logic data_ready_n
);
  logic sclk_q;
  logic [7:0] idle_q;
  logic [5:0] ones_q;
  logic rise;
  assign rise = sclk && !sclk_q;
  // ==========================================================
  // Serial edge and run-length tracking
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_q <= 1'b1;
      idle_q <= 8'h00;
      ones_q <= 6'h00;
    end else begin
      sclk_q <= sclk;
      if (sclk != sclk_q)
        idle_q <= 8'h00;
      else if (idle_q != 8'hFF)
        idle_q <= idle_q + 8'h01;
      // Saturates so that one long run of ones is judged only once
      if (rise && !din)
        ones_q <= 6'h00;
      else if (rise && ones_q != 6'h28)
        ones_q <= ones_q + 6'h01;
    end
  end
  // ==========================================================
  // Properties
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  reset_idle_a: assert property (
    $rose(presetn) |-> dout && data_ready_n && sclk && din)
    else $error("serial lines not idle after reset");
  sclk_low_a: assert property (
    $fell(sclk) |=> !sclk [*7] ##1 sclk)
    else $error("serial clock low phase not eight cycles");
  sclk_high_a: assert property (
    $rose(sclk) |=> sclk [*7])
    else $error("serial clock high phase too short");
  dout_hold_a: assert property (
    $fell(sclk) |=> $stable(dout) [*7])
    else $error("output data moved in low phase");
  din_hold_a: assert property (
    $rose(sclk) |=> $stable(din) [*3])
    else $error("input data moved after rising edge");
  dout_edge_a: assert property (
    $changed(dout) |-> sclk)
    else $error("output data changed while clock low");
  ready_rise_a: assert property (
    $rose(data_ready_n) |-> idle_q < 8'h0C)
    else $error("ready went high without serial cause");
  forty_ones_a: assert property (
    rise && din && ones_q == 6'h27 |-> ##[1:10] (data_ready_n && dout))
    else $error("forty ones did not reset the link");
endmodule // adc_link_checker

// ### verification/adc_serial_register_access_test.sv
`timescale 1ns/10ps
module adc_serial_register_access_test;
  import adc_link_pkg::*;
  localparam logic [7:0] IDENT = 8'h3C; // Arbitrary value
  localparam logic [23:0] GAIN_INIT = 24'h50_0000;
  localparam logic [2:0] WSEL [5] = '{SEL_MODE, SEL_SETUP, SEL_PINS,
                                      SEL_ZERO, SEL_GAIN};
  localparam logic [5:0] WLEN [5] = '{LEN_WORD, LEN_WORD, LEN_BYTE,
                                      LEN_WORD, LEN_WORD};
  // Fixed-zero fields are kept clear so either reading of them passes
  localparam logic [31:0] WMASK [5] = '{32'h00FF_BFFF, 32'h0091_FFDF,
    32'h0000_003F, 32'h00FF_FFFF, 32'h00FF_FFFF};
  typedef struct {string nm; logic [31:0] v; logic [31:0] m;} note_t;
  logic pclk, presetn, psel, penable, pwrite, watch, pready, pslverr, irq;
  logic conv_done, conv_error, conv_reference_missing_flag, err, serial_reset;
  logic [7:0] paddr, output_pin_control;
  logic [31:0] pwdata, prdata, rd, rnd;
  logic [23:0] conv_data, operating_mode, channel_setup;
  logic [23:0] zero_calibration, gain_calibration;
  logic [3:0] conv_channel;
  int fails, compares, resets;
  note_t notes[$];
  note_t nt;

  adc_link_if adc_link_if_i ();
  adc_serial_device #(.IDENT_VALUE(IDENT), .GAIN_RESET(GAIN_INIT))
    adc_serial_device_i (.pclk(pclk), .presetn(presetn),
    .link(adc_link_if_i.device), .conv_done(conv_done),
    .conv_data(conv_data), .conv_error(conv_error), .conv_reference_missing_flag(conv_reference_missing_flag),
    .conv_channel(conv_channel), .operating_mode(operating_mode),
    .channel_setup(channel_setup), .output_pin_control(output_pin_control),
    .zero_calibration(zero_calibration), .gain_calibration(gain_calibration),
    .serial_reset(serial_reset));
  adc_serial_host adc_serial_host_i (.pclk(pclk), .presetn(presetn),
    .link(adc_link_if_i.host), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq));
  adc_link_checker adc_link_checker_i (.pclk(pclk), .presetn(presetn),
    .sclk(adc_link_if_i.sclk), .din(adc_link_if_i.din),
    .dout(adc_link_if_i.dout), .data_ready_n(adc_link_if_i.data_ready_n));

  always #2 pclk = ~pclk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [23:0] reg_out(input logic [2:0] sel);
    case (sel)
      SEL_MODE: return operating_mode;
      SEL_SETUP: return channel_setup;
      SEL_PINS: return 24'(output_pin_control);
      SEL_ZERO: return zero_calibration;
      default: return gain_calibration;
    endcase
  endfunction

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ==========================================================
  // APB master: request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic c, input string nm,
                     input logic [31:0] e,
                     input logic [31:0] m = 32'hFFFF_FFFF);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    watch <= c;
    if (c)
      notes.push_back('{nm, e, m});
    @(posedge pclk);
    penable <= 1'b1;
    // No timeout here: pready or else the watchdog ends this wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    watch <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 1'b0, "", 32'h0000_0000);
  endtask

  task automatic rq(input logic [7:0] a, input string nm,
                    input logic [31:0] e,
                    input logic [31:0] m = 32'hFFFF_FFFF);
    apb(1'b0, a, 32'h0000_0000, 1'b1, nm, e, m);
  endtask

  task automatic xfer(input logic [7:0] cmd, input logic [5:0] len,
                      input logic [31:0] d, input logic [2:0] fl);
    int n;
    wr(ADDR_TX_DATA, d);
    wr(ADDR_TX_CMD, {13'h0000, fl, 2'h0, len, cmd});
    n = 0;
    do begin
      apb(1'b0, ADDR_LINK_STATE, 32'h0000_0000, 1'b0, "", 32'h0000_0000);
      n++;
    end while (rd[0] !== 1'b0 && n < 2000);
    if (rd[0] !== 1'b0) begin
      fails++;
      wrap_up();
    end
  endtask

  task automatic rdreg(input logic [7:0] cmd, input logic [5:0] len,
                       input logic [31:0] e, input string nm);
    xfer(cmd, len, 32'h0000_0000, 3'h0);
    // Bits above the last len received hold command-phase output
    rq(ADDR_RX_DATA, nm, e, 32'hFFFF_FFFF >> (LEN_LONG - len));
  endtask

  task automatic conv(input logic [23:0] d, input logic e, input logic nr,
                      input logic [3:0] ch);
    @(posedge pclk);
    conv_done <= 1'b1;
    conv_data <= d;
    conv_error <= e;
    conv_reference_missing_flag <= nr;
    conv_channel <= ch;
    @(posedge pclk);
    conv_done <= 1'b0;
  endtask

  task automatic regs_at_reset();
    check("mode", 32'(operating_mode), 32'(MODE_RESET));
    check("setup", 32'(channel_setup), 32'(SETUP_RESET));
    check("pins", 32'(output_pin_control), 32'(PINS_RESET));
    check("zero", 32'(zero_calibration), 32'(ZERO_RESET));
    check("gain", 32'(gain_calibration), 32'(GAIN_INIT));
  endtask

  // ==========================================================
  // Result watcher: every noted APB read is compared here
  always @(posedge pclk) begin
    if (serial_reset === 1'b1)
      resets++;
    if (psel && penable && pready === 1'b1 && !pwrite && watch &&
        notes.size() > 0) begin
      nt = notes.pop_front();
      check(nt.nm, prdata & nt.m, nt.v);
    end
  end

  initial begin
    #300000;
    fails++;
    wrap_up();
  end

  initial begin
    logic [31:0] v;
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, watch, conv_done, conv_error, conv_reference_missing_flag} = '0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    conv_data = 24'h00_0000;
    conv_channel = 4'h0;
    rnd = 32'h0000_0006;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    regs_at_reset();
    wr(ADDR_IRQ_MASK, 32'h0000_0001);
    rq(ADDR_IRQ_MASK, "irq_mask", 32'h0000_0001);
    rdreg(8'h43, LEN_BYTE, 32'(STATUS_RESET), "status");
    repeat (2) @(posedge pclk);
    check("irq", 32'(irq), 32'h0000_0001);
    rq(ADDR_IRQ_STATUS, "irq_status", 32'h0000_0001);
    repeat (2) @(posedge pclk);
    check("irq", 32'(irq), 32'h0000_0000);
    wr(ADDR_IRQ_MASK, 32'h0000_0000);
    rdreg({2'b01, SEL_IDENT, 3'h0}, LEN_BYTE, 32'(IDENT), "ident");
    repeat (2) @(posedge pclk);
    check("irq", 32'(irq), 32'h0000_0000);
    wr(ADDR_IRQ_MASK, 32'h0000_0003);
    repeat (2) @(posedge pclk);
    check("irq", 32'(irq), 32'h0000_0001);
    rq(ADDR_IRQ_STATUS, "irq_status", 32'h0000_0001);
    rq(8'hFC, "unmapped", 32'h0000_0000);
    check("slverr", 32'(err), 32'h0000_0001);
    for (int i = 0; i < 5; i++) begin
      rnd = lfsr(rnd);
      v = rnd & WMASK[i];
      xfer({2'b00, WSEL[i], 3'h0}, WLEN[i], v, 3'h0);
      check("reg_out", 32'(reg_out(WSEL[i])), v);
      rdreg({2'b01, WSEL[i], 3'h0}, WLEN[i], v, "reg_back");
    end
    xfer(8'hFF, 6'h00, 32'h0000_0000, 3'h2);
    check("resets", 32'(resets), 32'h0000_0001);
    regs_at_reset();
    rdreg(8'h40, LEN_BYTE, 32'(STATUS_RESET), "status");
    rnd = lfsr(rnd);
    conv(rnd[23:0], 1'b1, 1'b0, 4'h5);
    repeat (4) @(posedge pclk);
    check("ready", 32'(adc_link_if_i.data_ready_n), 32'h0000_0000);
    rdreg(8'h40, LEN_BYTE, 32'h0000_0045, "status");
    rdreg(8'h58, LEN_WORD, 32'(rnd[23:0]), "result");
    repeat (8) @(posedge pclk);
    check("ready", 32'(adc_link_if_i.data_ready_n), 32'h0000_0001);
    xfer(CMD_CONTINUOUS_RESULT_READ_ENTER, 6'h00, 32'h0000_0000, 3'h0);
    for (int k = 0; k < 3; k++) begin
      rnd = lfsr(rnd);
      conv(rnd[23:0], 1'b0, 1'b1, 4'(k));
      if (k < 2) begin
        xfer(8'h00, LEN_WORD, 32'h0000_0000, 3'h5);
        rq(ADDR_RX_DATA, "stream", 32'(rnd[23:0]));
      end
    end
    xfer(CMD_CONTINUOUS_RESULT_READ_EXIT, 6'h00, 32'h0000_0000, 3'h4);
    rdreg(8'h40, LEN_BYTE, 32'h0000_0022, "status");
    rdreg(8'h58, LEN_WORD, 32'(rnd[23:0]), "result");
    // Status appended to the result, with parity enabled
    xfer({2'b00, SEL_MODE, 3'h0}, LEN_WORD, 32'(MODE_RESET) |
         (32'h0000_0001 << MODE_STATUS_APPEND_BIT) |
         (32'h0000_0001 << MODE_PARITY_EN_BIT), 3'h0);
    rnd = lfsr(rnd);
    conv(rnd[23:0], 1'b0, 1'b0, 4'h3);
    rq(ADDR_IRQ_STATUS, "irq_status", 32'h0000_0003);
    rdreg(8'h58, LEN_LONG, {rnd[23:0], 3'h0, ^rnd[23:0], 4'h3},
          "result_status");
    wrap_up();
  end
endmodule // adc_serial_register_access_test
